// ### bench/ctrl_model.sv
// Controller model: parameter writes, record reads and acknowledges
module ctrl_model
(
  // Clock
  input wire logic clk,
  // Record answer
  input wire logic recordValid,
  input wire logic recordError,
  input wire logic [7:0] recordData,
  // Requests
  output logic paramWrite,
  output logic [7:0] paramRecord,
  output logic [4:0] paramByte,
  output logic [7:0] paramData,
  output logic recordRead,
  output logic [7:0] recordSet,
  output logic [4:0] recordByte,
  output logic procIrqAck,
  output logic diagAck
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {paramWrite, paramRecord, paramByte, paramData} = '0;
    {recordRead, recordSet, recordByte, procIrqAck, diagAck} = '0;
  end
  // Any parameter record is written at once, whatever is pending
  // Released fields show inverted values so stale data cannot match
  task automatic wr(input logic [7:0] r, input logic [4:0] b, input logic [7:0] d);
    @(posedge clk);
    paramWrite <= 1'b1;
    paramRecord <= r;
    paramByte <= b;
    paramData <= d;
    @(posedge clk);
    paramWrite <= 1'b0;
    paramRecord <= ~r;
    paramByte <= ~b;
    paramData <= ~d;
  endtask
  // Answer is taken at the edge after the read is sampled
  task automatic rd(input logic [7:0] s, input logic [4:0] b, output logic [7:0] d,
                    output logic e);
    @(posedge clk);
    recordRead <= 1'b1;
    recordSet <= s;
    recordByte <= b;
    @(posedge clk);
    recordRead <= 1'b0;
    recordSet <= ~s;
    recordByte <= ~b;
    @(posedge clk);
    d = (recordValid === 1'b1) ? recordData : 'x;
    e = recordError;
  endtask
  task automatic pulse(input logic a, input logic g);
    @(posedge clk);
    procIrqAck <= a;
    diagAck <= g;
    @(posedge clk);
    procIrqAck <= 1'b0;
    diagAck <= 1'b0;
  endtask
endmodule

// ### bench/dual_input_filter_irq_diag_chk.sv
// Timing checker for record reads, process interrupt and diagnostic interrupt
module dual_input_filter_irq_diag_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Record reads
  input wire logic recordRead,
  input wire logic [7:0] recordSet,
  input wire logic [4:0] recordByte,
  input wire logic recordValid,
  input wire logic recordError,
  input wire logic [7:0] recordData,
  // Interrupts
  input wire logic procIrq,
  input wire logic procIrqAck,
  input wire logic [7:0] procEdgeFlags,
  input wire logic [7:0] procInputSnapshot,
  input wire logic [1:0] inputState,
  input wire logic diagIrqIncoming,
  input wire logic diagIrqGoing,
  input wire logic moduleFaultLed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_read_answer: assert property (recordRead |=> recordValid)
    else $error("read not answered next cycle");
  a_no_spurious: assert property (recordValid |-> $past(recordRead))
    else $error("answer without read");
  a_short_limit: assert property (recordRead && recordSet == 8'h00 && recordByte >= 5'h04
    |=> recordError && recordData == 8'h00) else $error("short set overrun not refused");
  a_class_byte: assert property (recordRead && recordSet == 8'h01 && recordByte == 5'h01
    |=> !recordError && recordData == 8'h1F) else $error("module class byte wrong");
  a_kind_byte: assert property (recordRead && recordSet == 8'h01 && recordByte == 5'h04
    |=> !recordError && recordData == 8'h70) else $error("channel kind byte wrong");
  a_count_byte: assert property (recordRead && recordSet == 8'h01 && recordByte == 5'h06
    |=> recordData == 8'h02) else $error("channel count byte wrong");
  a_irq_holds: assert property (procIrq && !procIrqAck |=> procIrq)
    else $error("process interrupt dropped without ack");
  a_record_bits: assert property (procIrq |-> procEdgeFlags[7:2] == 6'h00
    && procInputSnapshot[7:2] == 6'h00 && procEdgeFlags[1:0] != 2'h0)
    else $error("process record bits wrong");
  a_snap_state: assert property ($rose(procIrq) |->
    procInputSnapshot[1:0] == inputState)
    else $error("snapshot differs from filtered levels");
  a_led_start: assert property ($rose(moduleFaultLed) |-> diagIrqIncoming)
    else $error("fault led on without incoming");
  a_incoming_led: assert property (diagIrqIncoming |->
    moduleFaultLed ##1 !diagIrqIncoming)
    else $error("incoming pulse or led wrong");
  a_going_ends: assert property (diagIrqGoing |->
    !moduleFaultLed && $past(moduleFaultLed))
    else $error("going without closing fault window");
  c_proc: cover property ($rose(procIrq));
  c_going: cover property (diagIrqGoing);
  c_refused: cover property (recordValid && recordError);
endmodule

bind dual_input_filter_irq_diag dual_input_filter_irq_diag_chk i_chk (.clk(clk), .srst(srst),
  .recordRead(recordRead), .recordSet(recordSet), .recordByte(recordByte),
  .recordValid(recordValid), .recordError(recordError), .recordData(recordData),
  .procIrq(procIrq), .procIrqAck(procIrqAck), .procEdgeFlags(procEdgeFlags),
  .procInputSnapshot(procInputSnapshot), .inputState(inputState),
  .diagIrqIncoming(diagIrqIncoming), .diagIrqGoing(diagIrqGoing),
  .moduleFaultLed(moduleFaultLed));

// ### bench/tb_dual_input_filter_irq_diag.sv
// Self-checking testbench of the dual filtered input block
module tb_dual_input_filter_irq_diag;
  timeunit 1ns;
  timeprecision 1ps;
  import dual_input_pkg::*;
  logic clk = 1'b0;
  logic srst, extErrorPin, paramWrite, recordRead, procIrqAck, diagAck;
  logic recordValid, recordError, procIrq, diagIrqIncoming, diagIrqGoing, moduleFaultLed;
  logic [1:0] inputChannel, inputState;
  logic [7:0] paramRecord, paramData, recordSet, recordData, procEdgeFlags, procInputSnapshot;
  logic [7:0] rdat;
  logic [4:0] paramByte, recordByte;
  logic [15:0] procTimestampLow;
  logic rerr;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Two cycles a microsecond keeps the 2731 us filter affordable
  dual_input_filter_irq_diag #(.CYCLES_PER_US(2)) i_dut (.clk(clk), .srst(srst),
    .inputChannel(inputChannel), .extErrorPin(extErrorPin), .paramWrite(paramWrite),
    .paramRecord(paramRecord), .paramByte(paramByte), .paramData(paramData),
    .recordRead(recordRead), .recordSet(recordSet), .recordByte(recordByte),
    .recordValid(recordValid), .recordError(recordError), .recordData(recordData),
    .procIrq(procIrq), .procIrqAck(procIrqAck), .procEdgeFlags(procEdgeFlags),
    .procInputSnapshot(procInputSnapshot), .procTimestampLow(procTimestampLow),
    .diagIrqIncoming(diagIrqIncoming), .diagIrqGoing(diagIrqGoing), .diagAck(diagAck),
    .moduleFaultLed(moduleFaultLed), .inputState(inputState));
  ctrl_model i_ctrl (.clk(clk), .recordValid(recordValid), .recordError(recordError),
    .recordData(recordData), .paramWrite(paramWrite), .paramRecord(paramRecord),
    .paramByte(paramByte), .paramData(paramData), .recordRead(recordRead),
    .recordSet(recordSet), .recordByte(recordByte), .procIrqAck(procIrqAck),
    .diagAck(diagAck));
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rec(input logic [7:0] s, input logic [4:0] b, input logic [7:0] d, input logic e);
    i_ctrl.rd(s, b, rdat, rerr);
    cmp(rdat, d);
    cmp(rerr, e);
  endtask
  task automatic wait_hi(ref logic s, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (s === 1'b1)
        return;
    end
    failures++;
    $display("ERROR %0t wait expired", $time);
  endtask
  // Pins move on even cycles only, so edges keep one phase to the tick
  task automatic pin(input int ch, input logic v, output int t);
    @(posedge clk);
    while (cyc[0])
      @(posedge clk);
    t = cyc;
    inputChannel[ch] <= v;
  endtask
  task automatic t_fixed();
    rec(8'h01, 5'h01, 8'h1F, 1'b0);
    rec(8'h01, 5'h04, 8'h70, 1'b0);
    rec(8'h01, 5'h05, 8'h00, 1'b0);
    rec(8'h01, 5'h06, 8'h02, 1'b0);
    rec(8'h00, 5'h01, 8'h1F, 1'b0);
    rec(8'h00, 5'h04, 8'h00, 1'b1);
    rec(8'h01, 5'h14, 8'h00, 1'b1);
    rec(8'h02, 5'h00, 8'h00, 1'b1);
  endtask
  task automatic t_filter();
    int t;
    i_ctrl.wr(8'h01, 5'h00, 8'h0C);
    pin(0, 1'b1, t);
    repeat (5400) @(posedge clk);
    cmp(inputState, 2'h0);
    repeat (200) @(posedge clk);
    cmp(inputState, 2'h1);
    cmp(procIrq, 1'b0);
    i_ctrl.wr(8'h01, 5'h00, 8'h00);
    i_ctrl.wr(8'h01, 5'h01, 8'h00);
    pin(0, 1'b0, t);
    repeat (20) @(posedge clk);
    cmp(inputState, 2'h0);
  endtask
  task automatic t_proc();
    int t0;
    int t1;
    logic [15:0] s0;
    i_ctrl.wr(8'h80, 5'h00, 8'hFD);
    i_ctrl.wr(8'h80, 5'h01, 8'h02);
    pin(0, 1'b1, t0);
    wait_hi(procIrq, 40);
    cmp(procEdgeFlags, 8'h01);
    cmp(procInputSnapshot, 8'h01);
    s0 = procTimestampLow;
    i_ctrl.pulse(1'b1, 1'b0);
    pin(1, 1'b1, t1);
    repeat (30) @(posedge clk);
    cmp(procIrq, 1'b0);
    pin(1, 1'b0, t1);
    wait_hi(procIrq, 40);
    cmp(procEdgeFlags, 8'h02);
    cmp(procInputSnapshot, 8'h01);
    cmp(16'(procTimestampLow - s0), 16'((t1 - t0) / 2));
    pin(0, 1'b0, t0);
    repeat (10) @(posedge clk);
    pin(0, 1'b1, t0);
    repeat (30) @(posedge clk);
    cmp(moduleFaultLed, 1'b0);
    cmp(procEdgeFlags, 8'h02);
    rec(8'h01, 5'h07, 8'h01, 1'b0);
    rec(8'h01, 5'h03, 8'h40, 1'b0);
    i_ctrl.pulse(1'b1, 1'b1);
  endtask
  task automatic t_diag();
    int t;
    int cp;
    int ci;
    logic [7:0] sLo;
    logic [15:0] sd;
    i_ctrl.wr(8'h00, 5'h00, 8'h40);
    i_ctrl.wr(8'h80, 5'h00, 8'h03);
    pin(0, 1'b0, t);
    repeat (10) @(posedge clk);
    pin(0, 1'b1, t);
    wait_hi(procIrq, 40);
    cp = cyc;
    pin(1, 1'b1, t);
    wait_hi(diagIrqIncoming, 40);
    ci = cyc;
    cmp(moduleFaultLed, 1'b1);
    rec(8'h01, 5'h07, 8'h02, 1'b0);
    rec(8'h01, 5'h00, 8'h09, 1'b0);
    // Stamp lies half the cycle distance after the process stamp, tick phase aside
    i_ctrl.rd(8'h01, 5'h10, sLo, rerr);
    i_ctrl.rd(8'h01, 5'h11, rdat, rerr);
    sd = {rdat, sLo} - procTimestampLow - 16'((ci - cp) / 2);
    cmp(16'(sd > 16'h0001), 16'h0000);
    rec(8'h01, 5'h13, 8'h00, 1'b0);
    pin(0, 1'b0, t);
    repeat (10) @(posedge clk);
    pin(0, 1'b1, t);
    repeat (20) @(posedge clk);
    cmp(procEdgeFlags, 8'h01);
    rec(8'h01, 5'h03, 8'h48, 1'b0);
    i_ctrl.pulse(1'b1, 1'b1);
    wait_hi(diagIrqGoing, 20);
    cmp(moduleFaultLed, 1'b0);
    @(posedge clk);
    extErrorPin <= 1'b1;
    wait_hi(diagIrqIncoming, 20);
    rec(8'h00, 5'h00, 8'h05, 1'b0);
    extErrorPin <= 1'b0;
    i_ctrl.pulse(1'b0, 1'b1);
    wait_hi(diagIrqGoing, 20);
  endtask
  initial
  begin
    srst = 1'b1;
    inputChannel = 2'h0;
    extErrorPin = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_fixed();
    t_filter();
    t_proc();
    t_diag();
    give_verdict();
  end
endmodule

// ### verilog/dual_input_filter_irq_diag.sv
// Two-channel input filter, process interrupt record and diagnostic record logic
// Function
// (RULE1) Diagnostic enable byte: 00h turns diagnostic interrupts off, 40h turns them on.
// (RULE2) Per-channel delay byte selects filter; only codes 00h,02h,04h,07h,09h,0Ch allowed.
// (RULE3) Rising-edge enable byte: bit 0 channel 0, bit 1 channel 1; others reserved.
// (RULE4) Falling-edge enable byte: bit 0 channel 0, bit 1 channel 1; others reserved.
// (RULE5) An enabled edge raises a process interrupt toward the controller.
// (RULE6) Process record byte 0 flags edge on channel 0 and channel 1.
// (RULE7) Process record byte 1 holds input levels at the interrupt instant.
// (RULE8) Free-running 32-bit microsecond counter, zero at reset, wraps at maximum.
// (RULE9) Process record carries low 16 counter bits latched at the interrupt.
// (RULE10) When enabled, issue incoming diagnostic interrupt, then going once cause clears.
// (RULE11) Channel events between incoming and going diagnostic interrupts are discarded.
// (RULE12) Fault indicator is on from incoming until going diagnostic interrupt.
// (RULE13) Summary byte: bit 0 module failure, bit 2 external, bit 3 channel error.
// (RULE14) Overflow byte bit 3 marks diagnostic buffer overflow; raises diagnostic interrupt.
// (RULE15) Overflow byte bit 6 marks a lost process interrupt.
// (RULE16) Module information byte reads 1Fh: digital class with channel info.
// (RULE17) Channel type byte reads 70h for digital input.
// (RULE18) Diagnostic bits per channel read 00h, channel count reads 02h.
// (RULE19) Channel error byte flags a lost edge on channel 0 or 1.
// (RULE20) Full diagnostic record is set 01h; first four bytes alone are set 00h.
// (RULE21) Diagnostic record holds full microsecond counter latched at the diagnostic event.
// (RULE22) Controller writes the diagnostic enable record only while the system is stopped.
// (RULE23) Edges and reported levels come from the filtered inputs.
// (RULE24) Enabled edge while a process interrupt is pending sets lost flags, raises diagnostic.
module dual_input_filter_irq_diag
  import dual_input_pkg::*;
#(
  parameter int CYCLES_PER_US = dual_input_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Input pins
  input wire logic [1:0] inputChannel,
  input wire logic extErrorPin,
  // Parameter record writes
  input wire logic paramWrite,
  input wire logic [7:0] paramRecord,
  input wire logic [4:0] paramByte,
  input wire logic [7:0] paramData,
  // Diagnostic record reads
  input wire logic recordRead,
  input wire logic [7:0] recordSet,
  input wire logic [4:0] recordByte,
  output logic recordValid,
  output logic recordError,
  output logic [7:0] recordData,
  // Process interrupt
  output logic procIrq,
  input wire logic procIrqAck,
  output logic [7:0] procEdgeFlags,
  output logic [7:0] procInputSnapshot,
  output logic [dual_input_pkg::STAMP_LOW_WIDTH-1:0] procTimestampLow,
  // Diagnostic interrupt
  output logic diagIrqIncoming,
  output logic diagIrqGoing,
  input wire logic diagAck,
  output logic moduleFaultLed,
  // Filtered input area
  output logic [1:0] inputState
);
  import dual_input_pkg::*;

  // Illegal codes map to zero so the write decode can refuse them
  function automatic logic [FILTER_CNT_WIDTH-1:0] delay_us(input logic [7:0] code);
    case (code)
      DLY_CODE_1US: delay_us = DLY_US_1;
      DLY_CODE_3US: delay_us = DLY_US_3;
      DLY_CODE_10US: delay_us = DLY_US_10;
      DLY_CODE_86US: delay_us = DLY_US_86;
      DLY_CODE_342US: delay_us = DLY_US_342;
      DLY_CODE_2731US: delay_us = DLY_US_2731;
      default: delay_us = '0;
    endcase
  endfunction

  // Pin synchronisers
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  // Timebase
  logic [15:0] preCnt_ff;
  logic usTick_ff;
  logic [TICKER_WIDTH-1:0] ticker_ff;
  // Parameters
  logic [7:0] diagEnable_ff;
  logic [7:0] delayCode_ff [2];
  logic [1:0] riseEn_ff;
  logic [1:0] fallEn_ff;
  // Filter
  logic [FILTER_CNT_WIDTH-1:0] filtCnt_ff [2];
  logic [1:0] filt_ff;
  logic [1:0] filtPrev_ff;
  // Process interrupt record
  logic procPending_ff;
  logic [1:0] procEdge_ff;
  logic [1:0] procSnap_ff;
  logic [STAMP_LOW_WIDTH-1:0] procStamp_ff;
  // Diagnostic record
  logic [1:0] edgeLost_ff;
  logic irqLost_ff;
  logic overflow_ff;
  logic [TICKER_WIDTH-1:0] diagStamp_ff;
  diag_state_t diagState_ff;
  diag_state_t nxt_diagState;
  logic incoming_ff;
  logic going_ff;
  // Read port
  logic rdValid_ff;
  logic rdErr_ff;
  logic [7:0] rdData_ff;

  // Decode
  wire tickWrap = (preCnt_ff == 16'(CYCLES_PER_US - 1));
  wire [15:0] nxt_preCnt = tickWrap ? 16'h0000 : preCnt_ff + 16'h0001;
  wire extErr = pinSync_ff[2];
  wire diagOn = (diagEnable_ff == DIAG_INTERRUPT_ENABLE_ON);
  wire diagBusy = (diagState_ff == DIAG_ACTIVE);
  wire wrDiagEn = paramWrite && (paramRecord == PREC_DIAG_ENABLE) && (paramByte == 5'h00)
    && ((paramData == DIAG_INTERRUPT_ENABLE_OFF) || (paramData == DIAG_INTERRUPT_ENABLE_ON));
  wire wrDelayRec = paramWrite && (paramRecord == PREC_INPUT_DELAY)
    && (delay_us(paramData) != '0);
  wire wrEdgeRec = paramWrite && (paramRecord == PREC_EDGE_ENABLE);
  wire wrRise = wrEdgeRec && (paramByte == PBYTE_RISING);
  wire wrFall = wrEdgeRec && (paramByte == PBYTE_FALLING);

  // Edge events on the filtered levels
  wire [1:0] riseEv = filt_ff & ~filtPrev_ff & riseEn_ff; // RULE3 RULE23
  wire [1:0] fallEv = ~filt_ff & filtPrev_ff & fallEn_ff; // RULE4 RULE23
  wire [1:0] edgeEv = riseEv | fallEv;
  wire anyEv = |edgeEv;
  wire accepted = anyEv && !diagBusy; // RULE11
  wire pendStays = procPending_ff && !procIrqAck;
  // Ack and a new edge in one cycle: the new record wins
  wire newProc = accepted && !pendStays; // RULE5
  wire lostEv = accepted && pendStays; // RULE24
  // A new loss wins over an ack in the same cycle
  wire [1:0] nxt_edgeLost = (diagAck ? 2'b00 : edgeLost_ff) | (lostEv ? edgeEv : 2'b00);
  wire nxt_irqLost = (irqLost_ff && !diagAck) || lostEv; // RULE15
  // Discarded events count as a diagnostic buffer overflow
  wire nxt_overflow = (overflow_ff && !diagAck) || (anyEv && diagBusy); // RULE14
  wire diagCause = (|edgeLost_ff) || irqLost_ff || overflow_ff || extErr;

  // Diagnostic record bytes
  wire [7:0] summaryByte = (8'(diagCause) << SUM_MODULE_FAIL)
    | (8'(extErr) << SUM_EXT_ERROR) | (8'(|edgeLost_ff) << SUM_CHANNEL_ERROR); // RULE13
  wire [7:0] overflowByte = (8'(overflow_ff) << OVF_BUFFER)
    | (8'(irqLost_ff) << OVF_IRQ_LOST); // RULE14 RULE15
  // Short set exposes only the first four bytes
  wire shortOk = (recordSet == DREC_SHORT) && (recordByte < DREC_SHORT_LEN);
  wire fullOk = (recordSet == DREC_FULL) && (recordByte < DREC_FULL_LEN);
  wire recOk = shortOk || fullOk; // RULE20
  logic [7:0] recByteVal;

  always_comb
  begin
    case (recordByte)
      DBYTE_SUMMARY: recByteVal = summaryByte;
      DBYTE_MODCLASS: recByteVal = MODULE_CLASS_INFO; // RULE16
      DBYTE_OVERFLOW: recByteVal = overflowByte;
      DBYTE_CHKIND: recByteVal = CHANNEL_KIND; // RULE17
      DBYTE_BITSPERCH: recByteVal = DIAG_BITS_PER_CH; // RULE18
      DBYTE_CHCOUNT: recByteVal = CHANNEL_COUNT; // RULE18
      DBYTE_EDGELOST: recByteVal = {6'h00, edgeLost_ff}; // RULE19
      DBYTE_STAMP0: recByteVal = diagStamp_ff[7:0]; // RULE21
      DBYTE_STAMP1: recByteVal = diagStamp_ff[15:8];
      DBYTE_STAMP2: recByteVal = diagStamp_ff[23:16];
      DBYTE_STAMP3: recByteVal = diagStamp_ff[31:24];
      default: recByteVal = 8'h00;
    endcase
  end

  always_comb
  begin
    nxt_diagState = diagState_ff;
    case (diagState_ff)
      DIAG_IDLE:
        if (diagOn && diagCause)
        begin
          nxt_diagState = DIAG_ACTIVE; // RULE10
        end
      // Going follows by itself once every cause has cleared
      DIAG_ACTIVE:
        if (!diagCause)
        begin
          nxt_diagState = DIAG_IDLE; // RULE10
        end
      default: nxt_diagState = DIAG_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    // Only the second stage is read by any logic
    pinMeta_ff <= {extErrorPin, inputChannel};
    pinSync_ff <= pinMeta_ff;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      preCnt_ff <= 16'h0000;
      usTick_ff <= 1'b0;
      ticker_ff <= '0;
    end
    else
    begin
      // Prescaler gives a one-cycle tick per microsecond
      preCnt_ff <= nxt_preCnt;
      usTick_ff <= tickWrap;
      if (usTick_ff)
      begin
        // All ones rolls over to zero by itself
        ticker_ff <= ticker_ff + 32'h0000_0001; // RULE8
      end
    end
  end

  // Parameters; reserved bits and illegal codes are not stored
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      diagEnable_ff <= RST_DIAG_INTERRUPT_ENABLE;
      riseEn_ff <= RST_EDGE_EN[1:0];
      fallEn_ff <= RST_EDGE_EN[1:0];
    end
    else
    begin
      // Only the two defined enable codes are stored
      if (wrDiagEn)
      begin
        diagEnable_ff <= paramData; // RULE1 RULE22
      end
      if (wrRise)
      begin
        riseEn_ff <= paramData[1:0] & EDGE_EN_MASK; // RULE3
      end
      if (wrFall)
      begin
        fallEn_ff <= paramData[1:0] & EDGE_EN_MASK; // RULE4
      end
    end
  end

  // Filter: level passes once stable for the selected number of microseconds
  for (genvar ch = 0; ch < 2; ch++)
  begin : gen_filter
    // Count restarts when the pin agrees again, so short glitches never pass
    wire stable = (pinSync_ff[ch] == filt_ff[ch]);
    wire expired = usTick_ff && (filtCnt_ff[ch] + 12'h001 >= delay_us(delayCode_ff[ch]));
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        delayCode_ff[ch] <= RST_INPUT_DELAY;
        filtCnt_ff[ch] <= '0;
        filt_ff[ch] <= 1'b0;
      end
      else
      begin
        if (wrDelayRec && (paramByte == 5'(ch)))
        begin
          delayCode_ff[ch] <= paramData; // RULE2
        end
        if (stable || expired)
        begin
          filtCnt_ff[ch] <= '0;
        end
        else if (usTick_ff)
        begin
          filtCnt_ff[ch] <= filtCnt_ff[ch] + 12'h001;
        end
        if (!stable && expired)
        begin
          filt_ff[ch] <= pinSync_ff[ch]; // RULE2 RULE23
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      filtPrev_ff <= 2'b00;
      procPending_ff <= 1'b0;
      procEdge_ff <= 2'b00;
      procSnap_ff <= 2'b00;
      procStamp_ff <= '0;
    end
    else
    begin
      filtPrev_ff <= filt_ff;
      // Ack drops the request; the record stays until the next accepted edge
      procPending_ff <= newProc || pendStays; // RULE5
      if (newProc)
      begin
        procEdge_ff <= edgeEv; // RULE6
        procSnap_ff <= filt_ff; // RULE7
        procStamp_ff <= ticker_ff[STAMP_LOW_WIDTH-1:0]; // RULE9
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      edgeLost_ff <= 2'b00;
      irqLost_ff <= 1'b0;
      overflow_ff <= 1'b0;
      diagStamp_ff <= '0;
      diagState_ff <= DIAG_IDLE;
      incoming_ff <= 1'b0;
      going_ff <= 1'b0;
    end
    else
    begin
      edgeLost_ff <= nxt_edgeLost; // RULE19 RULE24
      irqLost_ff <= nxt_irqLost;
      overflow_ff <= nxt_overflow;
      diagState_ff <= nxt_diagState;
      incoming_ff <= !diagBusy && (nxt_diagState == DIAG_ACTIVE); // RULE10
      going_ff <= diagBusy && (nxt_diagState == DIAG_IDLE); // RULE10
      // Stamp only on the incoming transition, not while active
      if (!diagBusy && (nxt_diagState == DIAG_ACTIVE))
      begin
        diagStamp_ff <= ticker_ff; // RULE21
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdValid_ff <= 1'b0;
      rdErr_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end
    else
    begin
      rdValid_ff <= recordRead;
      // Refused reads answer with the error strobe and zero data
      rdErr_ff <= recordRead && !recOk;
      rdData_ff <= (recordRead && recOk) ? recByteVal : 8'h00; // RULE20
    end
  end

  assign recordValid = rdValid_ff;
  assign recordError = rdErr_ff;
  assign recordData = rdData_ff;
  assign procIrq = procPending_ff;
  // Reserved bits of the record bytes read as zero
  assign procEdgeFlags = {6'h00, procEdge_ff};
  assign procInputSnapshot = {6'h00, procSnap_ff};
  assign procTimestampLow = procStamp_ff;
  assign diagIrqIncoming = incoming_ff;
  assign diagIrqGoing = going_ff;
  assign moduleFaultLed = diagState_ff[1]; // RULE12
  assign inputState = filt_ff;
endmodule

// ### verilog/dual_input_pkg.sv
// Constants for the two-channel filtered input, process interrupt and diagnostic block
package dual_input_pkg;
  // Timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKER_WIDTH = 32;
  localparam int STAMP_LOW_WIDTH = 16;
  localparam int FILTER_CNT_WIDTH = 12;

  // Parameter record sets and byte positions
  localparam logic [7:0] PREC_DIAG_ENABLE = 8'h00;
  localparam logic [7:0] PREC_INPUT_DELAY = 8'h01;
  localparam logic [7:0] PREC_EDGE_ENABLE = 8'h80;
  localparam logic [4:0] PBYTE_RISING = 5'h00;
  localparam logic [4:0] PBYTE_FALLING = 5'h01;

  // Diagnostic interrupt enable codes
  localparam logic [7:0] DIAG_INTERRUPT_ENABLE_OFF = 8'h00;
  localparam logic [7:0] DIAG_INTERRUPT_ENABLE_ON = 8'h40;

  // Input delay codes and their delays in microseconds
  localparam logic [7:0] DLY_CODE_1US = 8'h00;
  localparam logic [7:0] DLY_CODE_3US = 8'h02;
  localparam logic [7:0] DLY_CODE_10US = 8'h04;
  localparam logic [7:0] DLY_CODE_86US = 8'h07;
  localparam logic [7:0] DLY_CODE_342US = 8'h09;
  localparam logic [7:0] DLY_CODE_2731US = 8'h0C;
  localparam logic [FILTER_CNT_WIDTH-1:0] DLY_US_1 = 12'h001;
  localparam logic [FILTER_CNT_WIDTH-1:0] DLY_US_3 = 12'h003;
  localparam logic [FILTER_CNT_WIDTH-1:0] DLY_US_10 = 12'h00A;
  localparam logic [FILTER_CNT_WIDTH-1:0] DLY_US_86 = 12'h056;
  localparam logic [FILTER_CNT_WIDTH-1:0] DLY_US_342 = 12'h156;
  localparam logic [FILTER_CNT_WIDTH-1:0] DLY_US_2731 = 12'hAAB;

  // Parameter reset values
  localparam logic [7:0] RST_DIAG_INTERRUPT_ENABLE = 8'h00;
  localparam logic [7:0] RST_INPUT_DELAY = 8'h02;
  localparam logic [7:0] RST_EDGE_EN = 8'h00;
  localparam logic [1:0] EDGE_EN_MASK = 2'h3;

  // Diagnostic record sets, lengths and byte positions
  localparam logic [7:0] DREC_SHORT = 8'h00;
  localparam logic [7:0] DREC_FULL = 8'h01;
  localparam logic [4:0] DREC_SHORT_LEN = 5'h04;
  localparam logic [4:0] DREC_FULL_LEN = 5'h14;
  localparam logic [4:0] DBYTE_SUMMARY = 5'h00;
  localparam logic [4:0] DBYTE_MODCLASS = 5'h01;
  localparam logic [4:0] DBYTE_OVERFLOW = 5'h03;
  localparam logic [4:0] DBYTE_CHKIND = 5'h04;
  localparam logic [4:0] DBYTE_BITSPERCH = 5'h05;
  localparam logic [4:0] DBYTE_CHCOUNT = 5'h06;
  localparam logic [4:0] DBYTE_EDGELOST = 5'h07;
  localparam logic [4:0] DBYTE_STAMP0 = 5'h10;
  localparam logic [4:0] DBYTE_STAMP1 = 5'h11;
  localparam logic [4:0] DBYTE_STAMP2 = 5'h12;
  localparam logic [4:0] DBYTE_STAMP3 = 5'h13;

  // Diagnostic field positions
  localparam int SUM_MODULE_FAIL = 0;
  localparam int SUM_EXT_ERROR = 2;
  localparam int SUM_CHANNEL_ERROR = 3;
  localparam int OVF_BUFFER = 3;
  localparam int OVF_IRQ_LOST = 6;

  // Fixed read-only values
  localparam logic [7:0] MODULE_CLASS_INFO = 8'h1F;
  localparam logic [7:0] CHANNEL_KIND = 8'h70;
  localparam logic [7:0] DIAG_BITS_PER_CH = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT = 8'h02;

  // Diagnostic interrupt state
  typedef enum logic [1:0] {
    DIAG_IDLE = 2'b01,
    DIAG_ACTIVE = 2'b10
  } diag_state_t;
endpackage
